// File: logic/msw_pkg.sv
// Package for the microstep write sequencer: pin bundles, timing and table layout
package msw_pkg;
	localparam int unsigned CLK_PERIOD_NS = 4;
	localparam int unsigned SETUP_NS = 70;
	localparam int unsigned WRITE_LEN_NS = 50;
	localparam int unsigned SETUP_CYC = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned WRITE_CYC = (WRITE_LEN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned TIMER_W = 16;
	localparam int unsigned MAG_W = 7;
	localparam int unsigned SIGN_POS = 7;
	localparam int unsigned DECAY_POS = 8;
	localparam int unsigned ENTRY_W = 18;
	localparam int unsigned WIND_A_LSB = 0;
	localparam int unsigned WIND_B_LSB = 9;
	localparam logic [1:0] ADDR_WIND_A = 2'h0;
	localparam logic [1:0] ADDR_WIND_B = 2'h1;
	localparam logic [1:0] ADDR_DECAY_A = 2'h2;
	localparam logic [1:0] ADDR_DECAY_B = 2'h3;
	localparam logic MODE_DOUBLE = 1'h0;
	localparam logic MODE_SINGLE = 1'h1;

	typedef struct packed {
		logic cs_n;
		logic wr_n;
		logic [1:0] addr;
		logic [7:0] data;
	} msw_bus_s;

	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,
		ST_SETUP = 5'h02,
		ST_PULSE = 5'h04,
		ST_GAP = 5'h08,
		ST_WAIT = 5'h10
	} msw_state_e;
endpackage : msw_pkg

// File: logic/msw_rom.sv
// Step table memory with registered read data
`timescale 1ns/1ps
module msw_rom #(
	parameter int unsigned DEPTH = 64,
	parameter int unsigned AW = 6
) (
	input wire logic clk,
	input wire logic [AW-1:0] rd_addr,
	output logic [msw_pkg::ENTRY_W-1:0] rd_data,
	input wire logic wr_en,
	input wire logic [AW-1:0] wr_addr,
	input wire logic [msw_pkg::ENTRY_W-1:0] wr_data
);
	import msw_pkg::*;
	logic [ENTRY_W-1:0] mem [DEPTH];
	always_ff @(posedge clk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
		rd_data <= mem[rd_addr];
	end
endmodule : msw_rom

// File: logic/msw_sequencer.sv
// Step/direction driven write sequencer for a dual sign-magnitude winding DAC
// Behaviour
// - Each write pulse carries one address and one data byte only.
// - In double-pulse mode each step writes winding A then winding B as separate writes.
// - A setup interval separates the first and second write of a step.
// - Double-pulse mode issues two winding pulses per step, address changed between.
// - Double-pulse gap is the shortest legal setup time.
// - Single-pulse mode issues one winding write per step, each followed by a SLOT_CYC wait.
// - Single-pulse mode alternates winding registers; each winding write is one microstep.
// - An up/down counter addresses the step table memory.
// - Step input clocks the counter; direction selects up or down.
// - Slow decay is programmed when the step rate falls from high to low.
// - Fast decay is programmed when the step rate rises from low to high.
// - Table is loadable, so any resolution or full, half, wave sequence fits.
// - Steps are issued no faster than a ramped rate limit.
`timescale 1ns/1ps
module msw_sequencer #(
	parameter int unsigned DEPTH = 64,
	parameter int unsigned AW = 6,
	parameter int unsigned SLOT_CYC = 1000
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic step_pin,
	input wire logic dir_pin,
	input wire logic mode_single,
	input wire logic [AW-1:0] table_len_m1,
	input wire logic [msw_pkg::TIMER_W-1:0] fast_decay_period,
	input wire logic [msw_pkg::TIMER_W-1:0] ramp_start_period,
	input wire logic [msw_pkg::TIMER_W-1:0] ramp_min_period,
	input wire logic [msw_pkg::TIMER_W-1:0] ramp_dec,
	input wire logic tbl_wr_en,
	input wire logic [AW-1:0] tbl_wr_addr,
	input wire logic [msw_pkg::ENTRY_W-1:0] tbl_wr_data,
	output msw_pkg::msw_bus_s dac_bus,
	output logic [AW-1:0] position,
	output logic busy,
	output logic fast_decay
);
	import msw_pkg::*;

	logic step_s1_reg, step_s2_reg, step_s3_reg;
	logic dir_s1_reg, dir_s2_reg;
	logic [AW-1:0] pos_reg, pos_next;
	msw_state_e state_reg, state_next;
	logic [TIMER_W-1:0] timer_reg, timer_next;
	logic [TIMER_W-1:0] period_reg, period_next;
	logic [TIMER_W-1:0] since_reg;
	logic pend_reg, pend_next;
	logic second_reg, second_next;
	logic decay_phase_reg, decay_phase_next;
	logic fast_reg, fast_next;
	logic slot_wind_reg;
	logic [ENTRY_W-1:0] entry;
	msw_bus_s bus_reg, bus_next;

	wire step_rise = step_s2_reg & ~step_s3_reg;
	wire rate_ok = since_reg >= period_reg;
	wire take_step = pend_reg & rate_ok & (state_reg == ST_IDLE);
	wire at_top = pos_reg == table_len_m1;
	wire at_bot = pos_reg == '0;
	wire [AW-1:0] pos_up = at_top ? '0 : AW'(pos_reg + 1'b1);
	wire [AW-1:0] pos_dn = at_bot ? table_len_m1 : AW'(pos_reg - 1'b1);
	wire wind_b = decay_phase_reg ? second_reg : (mode_single ? slot_wind_reg : second_reg);
	wire [8:0] wind_field = wind_b ? entry[WIND_B_LSB +: 9] : entry[WIND_A_LSB +: 9];
	wire [7:0] wind_byte = {wind_field[SIGN_POS], wind_field[MAG_W-1:0]};
	wire [1:0] wind_addr = wind_b ? ADDR_WIND_B : ADDR_WIND_A;
	wire [1:0] decay_addr = second_reg ? ADDR_DECAY_B : ADDR_DECAY_A;
	wire [7:0] decay_byte = {7'h00, ~fast_reg};
	wire [TIMER_W-1:0] ramp_down = (period_reg > ramp_min_period + ramp_dec) ?
		TIMER_W'(period_reg - ramp_dec) : ramp_min_period;

	msw_rom #(.DEPTH(DEPTH), .AW(AW)) u_rom (
		.clk(clk),
		.rd_addr(pos_reg),
		.rd_data(entry),
		.wr_en(tbl_wr_en),
		.wr_addr(tbl_wr_addr),
		.wr_data(tbl_wr_data)
	);

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			step_s1_reg <= 1'b0;
			step_s2_reg <= 1'b0;
			step_s3_reg <= 1'b0;
			dir_s1_reg <= 1'b0;
			dir_s2_reg <= 1'b0;
		end else begin
			step_s1_reg <= step_pin;
			step_s2_reg <= step_s1_reg;
			step_s3_reg <= step_s2_reg;
			dir_s1_reg <= dir_pin;
			dir_s2_reg <= dir_s1_reg;
		end
	end

	// Counter moves once per pending step when it is taken, direction sampled at that moment
	always_comb begin
		pos_next = pos_reg;
		pend_next = pend_reg | step_rise;
		if (take_step) begin
			pend_next = step_rise;
			pos_next = dir_s2_reg ? pos_up : pos_dn;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			pos_reg <= '0;
			pend_reg <= 1'b0;
			since_reg <= '0;
			period_reg <= '1;
		end else begin
			pos_reg <= pos_next;
			pend_reg <= pend_next;
			period_reg <= period_next;
			if (take_step) begin
				since_reg <= '0;
			end else if (since_reg != '1) begin
				since_reg <= TIMER_W'(since_reg + 1'b1);
			end
		end
	end

	// Ramp: each step shortens the allowed period down to ramp_min_period; a long pause restarts from the slow end
	always_comb begin
		period_next = period_reg;
		if (since_reg > ramp_start_period) begin
			period_next = ramp_start_period;
		end else if (take_step) begin
			period_next = ramp_down;
		end
	end

	// Decay choice follows measured step spacing
	assign fast_next = take_step ? (since_reg < fast_decay_period) : fast_reg;

	always_comb begin
		state_next = state_reg;
		timer_next = timer_reg;
		bus_next = bus_reg;
		second_next = second_reg;
		decay_phase_next = decay_phase_reg;
		case (state_reg)
			ST_IDLE: begin
				bus_next.cs_n = 1'b1;
				bus_next.wr_n = 1'b1;
				if (take_step) begin
					second_next = 1'b0;
					decay_phase_next = fast_next != fast_reg;
					timer_next = TIMER_W'(SETUP_CYC + 1);
					state_next = ST_SETUP;
				end
			end
			ST_SETUP: begin
				// One address and one byte per pulse
				bus_next.addr = decay_phase_reg ? decay_addr : wind_addr;
				bus_next.data = decay_phase_reg ? decay_byte : wind_byte;
				bus_next.cs_n = 1'b0;
				if (timer_reg == '0) begin
					bus_next.wr_n = 1'b0;
					timer_next = TIMER_W'(WRITE_CYC);
					state_next = ST_PULSE;
				end else begin
					timer_next = TIMER_W'(timer_reg - 1'b1);
				end
			end
			ST_PULSE: begin
				if (timer_reg == '0) begin
					bus_next.wr_n = 1'b1;
					state_next = ST_GAP;
				end else begin
					timer_next = TIMER_W'(timer_reg - 1'b1);
				end
			end
			ST_GAP: begin
				bus_next.cs_n = 1'b1;
				if (decay_phase_reg && second_reg) begin
					decay_phase_next = 1'b0;
					second_next = 1'b0;
					timer_next = TIMER_W'(SETUP_CYC);
					state_next = ST_SETUP;
				end else if (decay_phase_reg || (!second_reg && mode_single == MODE_DOUBLE)) begin
					second_next = 1'b1;
					timer_next = TIMER_W'(SETUP_CYC);
					state_next = ST_SETUP;
				end else if (mode_single == MODE_SINGLE) begin
					timer_next = TIMER_W'(SLOT_CYC);
					state_next = ST_WAIT;
				end else begin
					state_next = ST_IDLE;
				end
			end
			ST_WAIT: begin
				if (timer_reg == '0) begin
					state_next = ST_IDLE;
				end else begin
					timer_next = TIMER_W'(timer_reg - 1'b1);
				end
			end
			default: begin
				state_next = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state_reg <= ST_IDLE;
			timer_reg <= '0;
			bus_reg <= '{cs_n: 1'b1, wr_n: 1'b1, addr: 2'h0, data: 8'h00};
			second_reg <= 1'b0;
			decay_phase_reg <= 1'b0;
			fast_reg <= 1'b0;
			slot_wind_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			timer_reg <= timer_next;
			bus_reg <= bus_next;
			second_reg <= second_next;
			decay_phase_reg <= decay_phase_next;
			fast_reg <= fast_next;
			// Single mode: each slot writes the other winding
			if (state_reg == ST_GAP && mode_single && !decay_phase_reg) begin
				slot_wind_reg <= ~slot_wind_reg;
			end
		end
	end

	assign dac_bus = bus_reg;
	assign position = pos_reg;
	assign busy = state_reg != ST_IDLE;
	assign fast_decay = fast_reg;
endmodule : msw_sequencer

// File: testbench/msw_dac_model.sv
// Behavioural model of the dual sign-magnitude winding DAC register file
`timescale 1ns/1ps
module msw_dac_model import msw_pkg::*; (
	input wire logic arst_n,
	input wire msw_pkg::msw_bus_s bus,
	output logic [7:0] wind_a,
	output logic [7:0] wind_b,
	output logic [7:0] decay_a,
	output logic [7:0] decay_b
);
	logic [7:0] reg_q [4];
	// One pulse loads only the addressed register, on the rising strobe
	always @(posedge bus.wr_n or negedge arst_n) begin
		if (!arst_n) begin
			reg_q <= '{default: 8'h00};
		end else if (!bus.cs_n) begin
			reg_q[bus.addr] <= bus.data;
		end
	end
	assign wind_a = reg_q[ADDR_WIND_A];
	assign wind_b = reg_q[ADDR_WIND_B];
	assign decay_a = reg_q[ADDR_DECAY_A];
	assign decay_b = reg_q[ADDR_DECAY_B];
endmodule : msw_dac_model

// File: testbench/msw_sequencer_props.sv
// Concurrent checks on the sequencer's write port
`timescale 1ns/1ps
module msw_sequencer_props import msw_pkg::*; #(
	parameter int unsigned DEPTH = 64,
	parameter int unsigned AW = 6,
	parameter int unsigned SLOT_CYC = 1000
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic mode_single,
	input wire logic [AW-1:0] table_len_m1,
	input wire msw_pkg::msw_bus_s dac_bus,
	input wire logic [AW-1:0] position,
	input wire logic busy
);
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	a_strobe_in_cs: assert property (!dac_bus.wr_n |-> !dac_bus.cs_n) else $error("strobe outside select");
	a_bus_held: assert property (!dac_bus.wr_n && $past(!dac_bus.wr_n) |-> $stable(dac_bus)) else $error("bus moved");
	a_pulse_len: assert property ($rose(dac_bus.wr_n) |-> $past(dac_bus.wr_n, 15) && !$past(dac_bus.wr_n, 14))
		else $error("pulse length");
	a_cs_setup: assert property ($fell(dac_bus.wr_n) |-> !$past(dac_bus.cs_n, 18)) else $error("select setup");
	a_cs_release: assert property ($rose(dac_bus.wr_n) |=> $rose(dac_bus.cs_n)) else $error("select release");
	a_busy_cover: assert property (!dac_bus.cs_n |-> busy) else $error("write while idle");
	a_take_write: assert property ($changed(position) |-> ##[1:3] $fell(dac_bus.cs_n)) else $error("no write");
	a_pos_wrap: assert property ($changed(position) |->
		position == (($past(position) == table_len_m1) ? '0 : AW'($past(position) + 1)) ||
		position == (($past(position) == '0) ? table_len_m1 : AW'($past(position) - 1))) else $error("bad count");
	a_pair_ab: assert property ($rose(dac_bus.wr_n) && dac_bus.addr == ADDR_WIND_A && !mode_single
		|-> ##[2:30] $fell(dac_bus.wr_n) && dac_bus.addr == ADDR_WIND_B) else $error("second write late");
	c_double: cover property ($rose(dac_bus.wr_n) && dac_bus.addr == ADDR_WIND_B && !mode_single);
	c_single: cover property ($rose(dac_bus.wr_n) && mode_single);
	c_wrap: cover property ($changed(position) && position == '0);
	c_decay: cover property ($rose(dac_bus.wr_n) && dac_bus.addr == ADDR_DECAY_A);
endmodule : msw_sequencer_props
bind msw_sequencer msw_sequencer_props #(.DEPTH(DEPTH), .AW(AW), .SLOT_CYC(SLOT_CYC)) msw_sequencer_props_inst (
	.clk(clk), .arst_n(arst_n), .mode_single(mode_single), .table_len_m1(table_len_m1),
	.dac_bus(dac_bus), .position(position), .busy(busy));

// File: testbench/msw_sequencer_tb_top.sv
// Self-checking bench for the microstep write sequencer
`timescale 1ns/1ps
module msw_sequencer_tb_top;
	import msw_pkg::*;
	logic clk = 1'b0, arst_n = 1'b0, step_pin = 1'b0, dir_pin = 1'b1, mode_single = 1'b0, tbl_wr_en = 1'b0;
	logic [1:0] table_len_m1 = 2'h3, tbl_wr_addr = 2'h0, position;
	logic [17:0] tbl_wr_data = 18'h00000;
	logic [15:0] fdp = 16'h0080, rsp = 16'h0100, rmp = 16'h0040, rdc = 16'h0010;
	msw_bus_s dac_bus;
	logic busy, fast_decay;
	logic [7:0] wind_a, wind_b, decay_a, decay_b;
	int errors = 0, n_compared = 0, n_wr = 0;
	always #2 clk = ~clk;
	msw_sequencer #(.DEPTH(4), .AW(2), .SLOT_CYC(20)) msw_sequencer_inst (.clk(clk), .arst_n(arst_n),
		.step_pin(step_pin), .dir_pin(dir_pin), .mode_single(mode_single), .table_len_m1(table_len_m1),
		.fast_decay_period(fdp), .ramp_start_period(rsp), .ramp_min_period(rmp), .ramp_dec(rdc),
		.tbl_wr_en(tbl_wr_en), .tbl_wr_addr(tbl_wr_addr), .tbl_wr_data(tbl_wr_data), .dac_bus(dac_bus),
		.position(position), .busy(busy), .fast_decay(fast_decay));
	msw_dac_model msw_dac_model_inst (.arst_n(arst_n), .bus(dac_bus), .wind_a(wind_a), .wind_b(wind_b),
		.decay_a(decay_a), .decay_b(decay_b));
	// Winding writes only; decay writes may be slipped in ahead
	always @(posedge dac_bus.wr_n) if (dac_bus.cs_n === 1'b0 && dac_bus.addr < 2'h2) n_wr++;
	function automatic logic [17:0] ent(input int i);
		return {1'b0, 8'(8'h80 + i), 1'b0, 8'(8'h10 + i)};
	endfunction : ent
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// Bounds check for measured step spacings
	task automatic chk_range(input int got, input int lo, input int hi);
		n_compared++;
		if (got < lo || got > hi) begin
			errors++;
			$display("[FAIL] %0t: got %0d outside %0d..%0d", $time, got, lo, hi);
		end
	endtask : chk_range
	task automatic conclude;
		$display("errors=%0d n_compared=%0d", errors, n_compared);
		if (errors == 0 && n_compared > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : conclude
	// One step request: four cycles high, then low again
	task automatic step_pulse(input logic d);
		dir_pin <= d;
		step_pin <= 1'b1;
		repeat (4) @(posedge clk);
		step_pin <= 1'b0;
	endtask : step_pulse
	// Cycles until the counter moves; a stalled counter counts as a mismatch
	task automatic wait_move(output int n);
		logic [1:0] last;
		last = position;
		n = 0;
		while (position === last && n < 3000) begin
			@(posedge clk);
			n++;
		end
		if (n >= 3000) begin
			errors++;
			$display("[FAIL] %0t: counter never moved", $time);
		end
	endtask : wait_move
	task automatic do_step(input logic d);
		int k;
		step_pulse(d);
		wait_move(k);
		k = 0;
		while (busy !== 1'b0 && k < 3000) begin
			@(posedge clk);
			k++;
		end
		if (k >= 3000) begin
			errors++;
			$display("[FAIL] %0t: step never finished", $time);
		end
		repeat (300) @(posedge clk);
	endtask : do_step
	task automatic t_load;
		for (int i = 0; i < 4; i++) begin
			tbl_wr_en <= 1'b1;
			tbl_wr_addr <= 2'(i);
			tbl_wr_data <= ent(i);
			@(posedge clk);
		end
		tbl_wr_en <= 1'b0;
	endtask : t_load
	// Four steps up wrap to entry 0, one step down wraps back to the last entry
	task automatic t_double_wrap;
		int p;
		logic [17:0] e;
		n_wr = 0;
		for (int i = 1; i < 6; i++) begin
			p = (i < 5) ? i % 4 : 3;
			e = ent(p);
			do_step(i < 5);
			chk({6'h00, position}, 8'(p));
			chk(wind_a, e[7:0]);
			chk(wind_b, e[16:9]);
		end
		chk(8'(n_wr), 8'h0A);
		chk({7'h00, fast_decay}, 8'h00);
	endtask : t_double_wrap
	// One winding write per step, alternating, first slot on winding A
	task automatic t_single;
		logic [17:0] e0, e1;
		e0 = ent(0);
		e1 = ent(1);
		mode_single <= 1'b1;
		n_wr = 0;
		do_step(1'b1);
		chk({6'h00, position}, 8'h00);
		chk(wind_a, e0[7:0]);
		do_step(1'b1);
		chk({6'h00, position}, 8'h01);
		chk(wind_b, e1[16:9]);
		chk(wind_a, e0[7:0]);
		chk(8'(n_wr), 8'h02);
	endtask : t_single
	// Back-to-back requests: first spacing is the start period, the next one shorter
	task automatic t_ramp;
		int n0, gap1, gap2;
		step_pulse(1'b1);
		wait_move(n0);
		step_pulse(1'b1);
		wait_move(gap1);
		gap1 += 4;
		step_pulse(1'b1);
		wait_move(gap2);
		gap2 += 4;
		chk_range(gap1, int'(rsp), int'(rsp) + 40);
		chk_range(gap2, int'(rmp), gap1 - 1);
		chk({6'h00, position}, 8'h00);
		repeat (300) @(posedge clk);
	endtask : t_ramp
	// A high spacing limit makes every step fast, a low one makes it slow
	task automatic t_decay;
		logic [17:0] e;
		e = ent(3);
		mode_single <= 1'b0;
		fdp <= 16'hFFFF;
		do_step(1'b1);
		chk({7'h00, fast_decay}, 8'h01);
		chk(decay_a, 8'h00);
		chk(decay_b, 8'h00);
		fdp <= 16'h0001;
		do_step(1'b1);
		chk({7'h00, fast_decay}, 8'h00);
		chk(decay_a, 8'h01);
		chk(decay_b, 8'h01);
		fdp <= 16'hFFFF;
		do_step(1'b1);
		chk(decay_a, 8'h00);
		chk(decay_b, 8'h00);
		chk({6'h00, position}, 8'h03);
		chk(wind_a, e[7:0]);
		chk(wind_b, e[16:9]);
	endtask : t_decay
	initial begin
		repeat (6) @(posedge clk);
		arst_n <= 1'b1;
		t_load();
		repeat (300) @(posedge clk);
		t_double_wrap();
		t_single();
		t_ramp();
		t_decay();
		conclude();
	end
	initial begin
		#200000;
		errors++;
		conclude();
	end
endmodule : msw_sequencer_tb_top
